//--- rtl/spc_pkg.sv
package spc_pkg;

  // register offsets on the local port
  localparam logic [2:0] ADDR_BAUD_HI = 3'h0;
  localparam logic [2:0] ADDR_BAUD_LO = 3'h1;
  localparam logic [2:0] ADDR_FORMAT = 3'h2;
  localparam logic [2:0] ADDR_ENABLE = 3'h3;
  localparam logic [2:0] ADDR_STATUS = 3'h4;
  localparam logic [2:0] ADDR_EXTRA = 3'h6;
  localparam logic [2:0] ADDR_DATA = 3'h7;

  // values after reset
  localparam logic [12:0] BAUD_RESET = 13'h0004;
  localparam logic [7:0] FORMAT_RESET = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] EXTRA_RESET = 8'h00;

  // field positions in the extra control register
  localparam int EXTRA_RX_BIT8 = 7;
  localparam int EXTRA_TX_BIT8 = 6;
  localparam int EXTRA_TX_DIR = 5;
  localparam int EXTRA_LONG_BREAK = 0;

  // bit timing: sixteen baud ticks per bit, sample in the middle
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
  localparam logic [3:0] OVERSAMPLE_MID = 4'h7;

  // frame and data lengths in bit times
  localparam logic [3:0] FRAME_BITS_8 = 4'ha;
  localparam logic [3:0] FRAME_BITS_9 = 4'hb;
  localparam logic [3:0] LONG_BREAK_EXTRA = 4'h3;
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_9 = 4'h9;

  // line format control, laid out as its bits 7..0
  typedef struct packed {
    logic loop_select;
    logic stop_in_wait;
    logic receiver_source_select;
    logic char9;
    logic wake_on_mark;
    logic idle_line_type;
    logic parity_enable;
    logic parity_odd_select;
  } spc_format_type;

  // enable and interrupt control, laid out as its bits 7..0
  typedef struct packed {
    logic tx_empty_irq_en;
    logic tx_done_irq_en;
    logic rx_full_irq_en;
    logic quiet_line_irq_en;
    logic transmitter_on;
    logic receiver_on;
    logic receiver_standby;
    logic send_break_ctrl;
  } spc_enable_type;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } spc_rx_state_type;

  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_SHIFT = 1'b1
  } spc_tx_state_type;

endpackage

//--- rtl/spc_top.sv
`timescale 1ns/100ps
// Summary of operation
// (R1) loop select routes transmitter into receiver and ignores the input pin
// (R2) stop-in-wait set freezes bit timing while the processor waits
// (R3) source select counts only in loop mode: 0 internal, 1 single wire
// (R4) character length select adds a ninth data bit before stop
// (R5) wake method: 0 idle line, 1 address mark
// (R6) idle count starts after start bit (type 0) or after stop (type 1)
// (R7) parity enable generates and checks parity in the top data bit
// (R8) parity type 0 even count of ones, 1 odd
// (R9) each flag raises an interrupt request while its enable is set
// (R10) transmitter drives the output pin while on or busy; a loaded character is sent even when off
// (R11) in single wire mode the direction bit decides pin direction
// (R12) turning transmitter off then on queues an idle character
// (R13) pin stays driven until pending data, idle or break finish
// (R14) input pin is released when receiver off or loop select set
// (R15) standby holds receiver until wake condition, then clears itself
// (R16) send break queues one break, repeats while set, long option; the code repeats it only while the transmitter is also on
// (R17) a second break may be queued before software clears the bit
// (R18) enable register is readable and writable at any time
// (R19) baud tick divides clock by the divisor, sixteen ticks per bit, zero stops it
// (R20) empty flag set at reset and on load, full flag on receive
// (R21) transmitter replaces the top data bit with computed parity
module spc_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rd_data,
  input wire logic wait_mode,
  input wire logic rxd_in,
  output logic rxd_pin_owned,
  input wire logic txd_in,
  output logic txd_out,
  output logic txd_oe,
  output logic irq_req
);

  spc_pkg::spc_format_type fmt_q;
  spc_pkg::spc_enable_type en_q;
  spc_pkg::spc_enable_type en_new;
  logic [12:0] baud_divisor_q;
  logic [4:0] baud_hi_buf_q;
  logic [12:0] baud_cnt_q;
  logic baud_tick;
  logic [7:0] extra_q;
  logic [7:0] rd_data_q;
  logic status_seen_q;
  logic tx_buffer_empty_flag_q;
  logic [8:0] tx_buf_q;
  logic tx_done_flag;
  logic rx_buffer_full_flag_q;
  logic idle_flag_q;
  logic overrun_q;
  logic frame_err_q;
  logic parity_err_q;
  logic [8:0] rx_buf_q;
  logic wr_enable;
  logic wr_data_reg;
  logic rd_data_reg;
  logic rd_status;
  logic data_clear;
  logic [3:0] frame_bits;
  logic baud_active;
  spc_pkg::spc_tx_state_type tx_state_q;

  // pulses and levels decoded from the local port
  assign wr_enable = wr_stb && (addr == spc_pkg::ADDR_ENABLE);
  assign wr_data_reg = wr_stb && (addr == spc_pkg::ADDR_DATA);
  assign rd_data_reg = rd_stb && (addr == spc_pkg::ADDR_DATA);
  assign rd_status = rd_stb && (addr == spc_pkg::ADDR_STATUS);
  assign data_clear = rd_data_reg && status_seen_q;
  assign en_new = spc_pkg::spc_enable_type'(wr_data);
  assign frame_bits = fmt_q.char9 ? spc_pkg::FRAME_BITS_9 : spc_pkg::FRAME_BITS_8; // [R4]

  // even parity over the low bits, inverted for odd
  function automatic logic parity_of(input logic [8:0] bits, input logic odd);
    parity_of = (^bits) ^ odd;
  endfunction

  // line format and extra control registers
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      fmt_q <= spc_pkg::spc_format_type'(spc_pkg::FORMAT_RESET);
      extra_q <= spc_pkg::EXTRA_RESET;
    end
    else if (wr_stb && addr == spc_pkg::ADDR_FORMAT)
      fmt_q <= spc_pkg::spc_format_type'(wr_data);
    else if (wr_stb && addr == spc_pkg::ADDR_EXTRA)
      extra_q <= {1'b0, wr_data[6:0]};
  end

  // divisor high half waits in a buffer until the low half is written
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      baud_hi_buf_q <= spc_pkg::BAUD_RESET[12:8];
      baud_divisor_q <= spc_pkg::BAUD_RESET;
    end
    else if (wr_stb && addr == spc_pkg::ADDR_BAUD_HI)
      baud_hi_buf_q <= wr_data[4:0];
    else if (wr_stb && addr == spc_pkg::ADDR_BAUD_LO)
      baud_divisor_q <= {baud_hi_buf_q, wr_data};
  end

  // baud tick generator, one tick per sixteenth of a bit
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      baud_cnt_q <= 13'h0000;
    else if (baud_divisor_q == 13'h0000) // [R19]
      baud_cnt_q <= 13'h0000;
    else if (fmt_q.stop_in_wait && wait_mode) // [R2]
      baud_cnt_q <= baud_cnt_q; // frozen, resumes where it stopped
    else if (baud_tick || !baud_active)
      baud_cnt_q <= 13'h0000; // parked at zero so the first bit starts on time
    else
      baud_cnt_q <= baud_cnt_q + 13'h0001;
  end

  // tick also idles while neither direction is on and the shifter is idle, to save toggling
  assign baud_active = en_q.transmitter_on || en_q.receiver_on
    || (tx_state_q == spc_pkg::TX_SHIFT);
  // at or past the end also covers a divisor lowered mid count
  assign baud_tick = (baud_divisor_q != 13'h0000) && !(fmt_q.stop_in_wait && wait_mode)
    && (baud_cnt_q >= baud_divisor_q - 13'h0001) && baud_active; // [R19] [R2]

  // transmitter
  logic [13:0] tx_sh_q;
  logic [3:0] tx_bits_q;
  logic [3:0] tx_ph_q;
  logic preamble_pend_q;
  logic break_pend_q;
  logic tx_start_break;
  logic tx_start_idle;
  logic tx_start_data;
  logic [8:0] tx_word;
  logic [13:0] tx_frame;
  logic tx_line;

  // job selection: queued idle first, then break, then data
  assign tx_start_idle = (tx_state_q == spc_pkg::TX_IDLE) && preamble_pend_q;
  assign tx_start_break = (tx_state_q == spc_pkg::TX_IDLE) && !preamble_pend_q
    && (break_pend_q || (en_q.send_break_ctrl && en_q.transmitter_on)); // [R16] [R17]
  assign tx_start_data = (tx_state_q == spc_pkg::TX_IDLE) && !preamble_pend_q
    && !tx_start_break && !tx_buffer_empty_flag_q; // [R13]

  // data word with parity forced into its top bit
  always_comb
  begin
    tx_word = tx_buf_q;
    if (!fmt_q.char9)
      tx_word[8] = 1'b0;
    if (fmt_q.parity_enable && fmt_q.char9) // [R7] [R21]
      tx_word[8] = parity_of({1'b0, tx_buf_q[7:0]}, fmt_q.parity_odd_select); // [R8]
    else if (fmt_q.parity_enable)
      tx_word[7] = parity_of({2'b00, tx_buf_q[6:0]}, fmt_q.parity_odd_select); // [R8]
  end

  // frame: start, data lsb first, optional ninth bit, stop; ones above
  always_comb
  begin
    tx_frame = {14{1'b1}};
    if (fmt_q.char9)
      tx_frame[10:0] = {1'b1, tx_word, 1'b0}; // [R4]
    else
      tx_frame[9:0] = {1'b1, tx_word[7:0], 1'b0}; // [R4]
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      tx_state_q <= spc_pkg::TX_IDLE;
      tx_sh_q <= {14{1'b1}};
      tx_bits_q <= 4'h0;
      tx_ph_q <= 4'h0;
    end
    else
    begin
      case (tx_state_q)
        spc_pkg::TX_IDLE:
        begin
          tx_ph_q <= 4'h0;
          if (tx_start_idle)
          begin
            tx_sh_q <= {14{1'b1}}; // [R12]
            tx_bits_q <= frame_bits;
            tx_state_q <= spc_pkg::TX_SHIFT;
          end
          else if (tx_start_break)
          begin
            tx_sh_q <= 14'h0000;
            tx_bits_q <= frame_bits + (extra_q[spc_pkg::EXTRA_LONG_BREAK] ?
              spc_pkg::LONG_BREAK_EXTRA : 4'h0); // [R16]
            tx_state_q <= spc_pkg::TX_SHIFT;
          end
          else if (tx_start_data)
          begin
            tx_sh_q <= tx_frame;
            tx_bits_q <= frame_bits;
            tx_state_q <= spc_pkg::TX_SHIFT;
          end
        end
        spc_pkg::TX_SHIFT:
        begin
          if (baud_tick)
          begin
            tx_ph_q <= tx_ph_q + 4'h1;
            if (tx_ph_q == spc_pkg::OVERSAMPLE_LAST)
            begin
              tx_sh_q <= {1'b1, tx_sh_q[13:1]};
              tx_bits_q <= tx_bits_q - 4'h1;
              if (tx_bits_q == 4'h1)
                tx_state_q <= spc_pkg::TX_IDLE;
            end
          end
        end
        default:
          tx_state_q <= spc_pkg::TX_IDLE;
      endcase
    end
  end

  // queued idle and queued break requests; a new request wins over consumption
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      preamble_pend_q <= 1'b0;
      break_pend_q <= 1'b0;
    end
    else
    begin
      if (wr_enable && en_new.transmitter_on && !en_q.transmitter_on)
        preamble_pend_q <= 1'b1; // [R12]
      else if (tx_start_idle)
        preamble_pend_q <= 1'b0;
      if (wr_enable && en_new.send_break_ctrl && !en_q.send_break_ctrl)
        break_pend_q <= 1'b1; // [R16]
      else if (tx_start_break)
        break_pend_q <= 1'b0;
    end
  end

  // transmit buffer and its empty flag
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      tx_buffer_empty_flag_q <= 1'b1; // [R20]
      tx_buf_q <= 9'h000;
    end
    else if (wr_data_reg)
    begin
      tx_buf_q <= {extra_q[spc_pkg::EXTRA_TX_BIT8], wr_data};
      tx_buffer_empty_flag_q <= 1'b0;
    end
    else if (tx_start_data)
      tx_buffer_empty_flag_q <= 1'b1; // [R20]
  end

  assign tx_line = (tx_state_q == spc_pkg::TX_SHIFT) ? tx_sh_q[0] : 1'b1;
  assign tx_done_flag = tx_buffer_empty_flag_q && (tx_state_q == spc_pkg::TX_IDLE)
    && !preamble_pend_q && !break_pend_q && !(en_q.send_break_ctrl && en_q.transmitter_on);

  // pin stays driven after switch-off until the shifter and queues drain
  assign txd_out = tx_line;
  assign txd_oe = (en_q.transmitter_on || !tx_done_flag) // [R10] [R13]
    && !(fmt_q.loop_select && fmt_q.receiver_source_select
    && !extra_q[spc_pkg::EXTRA_TX_DIR]); // [R11]

  // receiver
  spc_pkg::spc_rx_state_type rx_state_q;
  logic rx_line;
  logic [3:0] rx_ph_q;
  logic [3:0] rx_bits_q;
  logic [8:0] rx_sh_q;
  logic [3:0] idle_cnt_q;
  logic idle_armed_q;
  logic rx_sample;
  logic rx_done;
  logic [8:0] rx_word;
  logic rx_msb;
  logic idle_hit;
  logic standby_wake;

  // input selection: own pin, internal loop or the shared single wire
  always_comb
  begin
    if (!fmt_q.loop_select)
      rx_line = rxd_in; // [R1]
    else if (fmt_q.receiver_source_select)
      rx_line = txd_in; // [R3]
    else
      rx_line = tx_line; // [R1] [R3]
  end

  assign rxd_pin_owned = en_q.receiver_on && !fmt_q.loop_select; // [R14]
  assign rx_sample = baud_tick && (rx_ph_q == spc_pkg::OVERSAMPLE_LAST);
  assign rx_done = (rx_state_q == spc_pkg::RX_STOP) && rx_sample;
  assign rx_word = fmt_q.char9 ? rx_sh_q : {1'b0, rx_sh_q[8:1]};
  assign rx_msb = fmt_q.char9 ? rx_word[8] : rx_word[7];
  assign idle_hit = (idle_cnt_q == frame_bits - 4'h1) && rx_sample && rx_line
    && (rx_state_q == spc_pkg::RX_IDLE);

  // address mark or idle line ends standby
  assign standby_wake = en_q.receiver_standby && (fmt_q.wake_on_mark ?
    (rx_done && rx_msb) : idle_hit); // [R5] [R15]

  always_ff @(posedge clk)
  begin
    if (!reset_n || !en_q.receiver_on)
    begin
      rx_state_q <= spc_pkg::RX_IDLE;
      rx_ph_q <= 4'h0;
      rx_bits_q <= 4'h0;
      rx_sh_q <= 9'h000;
    end
    else if (baud_tick)
    begin
      rx_ph_q <= rx_ph_q + 4'h1;
      case (rx_state_q)
        spc_pkg::RX_IDLE:
          if (!rx_line)
          begin
            rx_state_q <= spc_pkg::RX_START;
            rx_ph_q <= 4'h0;
          end
        spc_pkg::RX_START:
          if (rx_ph_q == spc_pkg::OVERSAMPLE_MID)
          begin
            // a glitch shorter than half a bit is not a start
            rx_state_q <= rx_line ? spc_pkg::RX_IDLE : spc_pkg::RX_DATA;
            rx_ph_q <= 4'h0;
            rx_bits_q <= 4'h0;
          end
        spc_pkg::RX_DATA:
          if (rx_sample)
          begin
            rx_sh_q <= {rx_line, rx_sh_q[8:1]};
            rx_bits_q <= rx_bits_q + 4'h1;
            if (rx_bits_q == (fmt_q.char9 ? spc_pkg::DATA_BITS_9 : spc_pkg::DATA_BITS_8)
              - 4'h1) // [R4]
              rx_state_q <= spc_pkg::RX_STOP;
          end
        spc_pkg::RX_STOP:
          if (rx_sample)
            rx_state_q <= spc_pkg::RX_IDLE;
        default:
          rx_state_q <= spc_pkg::RX_IDLE;
      endcase
    end
  end

  // idle detector counts high bit times; a low bit restarts it
  always_ff @(posedge clk)
  begin
    if (!reset_n || !en_q.receiver_on)
      idle_cnt_q <= 4'h0;
    else if (rx_sample && rx_state_q == spc_pkg::RX_STOP && fmt_q.idle_line_type)
      idle_cnt_q <= 4'h0; // [R6]
    else if (rx_sample && !rx_line)
      idle_cnt_q <= 4'h0;
    else if (rx_sample && rx_state_q != spc_pkg::RX_START && idle_cnt_q != 4'hf)
      idle_cnt_q <= idle_cnt_q + 4'h1; // [R6]
  end

  // receive data register and flags; a new event wins over a clear
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rx_buffer_full_flag_q <= 1'b0;
      idle_flag_q <= 1'b0;
      idle_armed_q <= 1'b0;
      overrun_q <= 1'b0;
      frame_err_q <= 1'b0;
      parity_err_q <= 1'b0;
      rx_buf_q <= 9'h000;
    end
    else
    begin
      if (data_clear)
      begin
        rx_buffer_full_flag_q <= 1'b0;
        idle_flag_q <= 1'b0;
        overrun_q <= 1'b0;
        frame_err_q <= 1'b0;
        parity_err_q <= 1'b0;
      end
      if (idle_hit && idle_armed_q && !en_q.receiver_standby)
      begin
        idle_flag_q <= 1'b1; // only once per run of idle
        idle_armed_q <= 1'b0;
      end
      // characters in standby are dropped, except a waking address mark
      if (rx_done && (!en_q.receiver_standby || standby_wake))
      begin
        if (rx_buffer_full_flag_q && !data_clear)
          overrun_q <= 1'b1; // old character kept, new one lost
        else
        begin
          rx_buf_q <= rx_word;
          rx_buffer_full_flag_q <= 1'b1; // [R20]
          idle_armed_q <= 1'b1;
          frame_err_q <= !rx_line;
          parity_err_q <= fmt_q.parity_enable
            && (parity_of(rx_word, 1'b0) != fmt_q.parity_odd_select); // [R7] [R8]
        end
      end
    end
  end

  // enable register: open to writes at any time; standby self-clears
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      en_q <= spc_pkg::spc_enable_type'(spc_pkg::ENABLE_RESET);
    else
    begin
      if (wr_enable)
        en_q <= en_new; // [R18]
      if (standby_wake && !(wr_enable && en_new.receiver_standby))
        en_q.receiver_standby <= 1'b0; // [R15]
    end
  end

  // status read arms the flag clearing sequence
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      status_seen_q <= 1'b0;
    else if (rd_status)
      status_seen_q <= 1'b1;
    else if (rd_data_reg)
      status_seen_q <= 1'b0;
  end

  // read data, valid only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!reset_n || !rd_stb)
      rd_data_q <= 8'h00;
    else
    begin
      case (addr)
        spc_pkg::ADDR_BAUD_HI: rd_data_q <= {3'h0, baud_divisor_q[12:8]};
        spc_pkg::ADDR_BAUD_LO: rd_data_q <= baud_divisor_q[7:0];
        spc_pkg::ADDR_FORMAT: rd_data_q <= fmt_q;
        spc_pkg::ADDR_ENABLE: rd_data_q <= en_q; // [R18]
        spc_pkg::ADDR_STATUS: rd_data_q <= {tx_buffer_empty_flag_q, tx_done_flag,
          rx_buffer_full_flag_q, idle_flag_q, overrun_q, 1'b0, frame_err_q, parity_err_q};
        spc_pkg::ADDR_EXTRA: rd_data_q <= {rx_buf_q[8], extra_q[6:0]};
        spc_pkg::ADDR_DATA: rd_data_q <= rx_buf_q[7:0];
        default: rd_data_q <= 8'h00;
      endcase
    end
  end

  assign rd_data = rd_data_q;

  // one request line from four flag and enable pairs
  assign irq_req = (en_q.tx_empty_irq_en && tx_buffer_empty_flag_q)
    || (en_q.tx_done_irq_en && tx_done_flag)
    || (en_q.rx_full_irq_en && rx_buffer_full_flag_q)
    || (en_q.quiet_line_irq_en && idle_flag_q); // [R9]

endmodule

//--- testbench/spc_checker.sv
`timescale 1ns/100ps
// port checker, control bits shadowed from software writes
module spc_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] rd_data,
  input wire logic wait_mode,
  input wire logic rxd_in,
  input wire logic rxd_pin_owned,
  input wire logic txd_in,
  input wire logic txd_out,
  input wire logic txd_oe,
  input wire logic irq_req
);
  logic [7:0] fmt_q;
  logic [7:0] en_q;
  logic [7:0] ex_q;
  logic sw_rx;
  // hardware clears only standby; the standby and break bits are never compared
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      fmt_q <= spc_pkg::FORMAT_RESET;
      en_q <= spc_pkg::ENABLE_RESET;
      ex_q <= spc_pkg::EXTRA_RESET;
    end
    else if (wr_stb)
    begin
      if (addr == spc_pkg::ADDR_FORMAT) fmt_q <= wr_data;
      if (addr == spc_pkg::ADDR_ENABLE) en_q <= wr_data;
      if (addr == spc_pkg::ADDR_EXTRA) ex_q <= wr_data;
    end
  end
  // single wire, pin turned to listen
  assign sw_rx = fmt_q[7] && fmt_q[5] && !ex_q[5];
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  a_pin_release: assert property (rxd_pin_owned == (en_q[2] && !fmt_q[7]))
    else $error("receive pin ownership wrong");
  a_tx_drive: assert property ((en_q[3] && !sw_rx) |-> txd_oe)
    else $error("transmit pin not driven");
  a_low_driven: assert property ((!txd_out && !sw_rx) |-> txd_oe)
    else $error("pin released while line low");
  a_rd_idle: assert property (!$past(rd_stb) |-> rd_data == 8'h00)
    else $error("read data outside read cycle");
  a_unmapped_zero: assert property ($past(rd_stb && addr == 3'h5) |-> rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_fmt_rdback: assert property ($past(rd_stb && addr == spc_pkg::ADDR_FORMAT) |->
    rd_data == fmt_q)
    else $error("format readback wrong");
  a_en_rdback: assert property ($past(rd_stb && addr == spc_pkg::ADDR_ENABLE) |->
    rd_data[7:2] == en_q[7:2])
    else $error("enable readback wrong");
  a_irq_masked: assert property (en_q[7:4] == 4'h0 |-> !irq_req)
    else $error("request with all enables clear");
  a_wait_freeze: assert property ((fmt_q[6] && wait_mode && $past(fmt_q[6] && wait_mode)
    && !$past(wr_stb) && !$past(wr_stb, 2) && !$past(wr_stb, 3)) |-> $stable(txd_out))
    else $error("line moved while frozen");
  c_irq: cover property (irq_req);
  c_tx_tail: cover property (!en_q[3] && !txd_out);
  c_frozen: cover property (fmt_q[6] && wait_mode && !txd_out);
endmodule

bind spc_top spc_checker u_chk (.clk(clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .wait_mode(wait_mode), .rxd_in(rxd_in),
  .rxd_pin_owned(rxd_pin_owned), .txd_in(txd_in), .txd_out(txd_out), .txd_oe(txd_oe),
  .irq_req(irq_req));

//--- testbench/spc_remote_node.sv
`timescale 1ns/100ps
// far serial node: sends 8-bit frames, decodes and measures the line
module spc_remote_node (
  input wire logic clk,
  input wire logic [15:0] bit_clks,
  input wire logic send_go,
  input wire logic [7:0] send_data,
  output logic line_out,
  output logic sending,
  input wire logic line_in,
  output logic [7:0] got_data,
  output logic [15:0] low_run
);
  logic [7:0] got_q;
  logic [15:0] run_q;
  initial
  begin
    line_out = 1'h1;
    sending = 1'h0;
    got_data = 8'h00;
    low_run = 16'h0000;
    run_q = 16'h0000;
  end
  // sender: start, data least significant first, stop
  always
  begin
    @(posedge clk);
    if (send_go)
    begin
      sending <= 1'h1;
      line_out <= 1'h0;
      repeat (bit_clks) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
        line_out <= send_data[i];
        repeat (bit_clks) @(posedge clk);
      end
      line_out <= 1'h1;
      repeat (bit_clks) @(posedge clk);
      sending <= 1'h0;
    end
  end
  // decoder samples mid bit; a break just reads as zero
  always
  begin
    @(posedge clk);
    if (!line_in)
    begin
      repeat (bit_clks / 2) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (bit_clks) @(posedge clk);
        got_q[i] = line_in;
      end
      got_data = got_q;
      while (!line_in) @(posedge clk);
    end
  end
  // length of the last low stretch, for break timing
  always @(posedge clk)
  begin
    if (!line_in)
      run_q <= run_q + 16'h0001;
    else if (run_q != 16'h0000)
    begin
      low_run <= run_q;
      run_q <= 16'h0000;
    end
  end
endmodule

//--- testbench/spc_top_bench.sv
`timescale 1ns/100ps
module spc_top_bench;
  localparam logic [2:0] FMT = spc_pkg::ADDR_FORMAT;
  localparam logic [2:0] ENA = spc_pkg::ADDR_ENABLE;
  localparam logic [2:0] STA = spc_pkg::ADDR_STATUS;
  localparam logic [2:0] EXT = spc_pkg::ADDR_EXTRA;
  localparam logic [2:0] DAT = spc_pkg::ADDR_DATA;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wr_data = 8'h00;
  logic wr_stb = 1'h0;
  logic rd_stb = 1'h0;
  logic wait_mode = 1'h0;
  logic hold_low = 1'h0;
  logic node_go = 1'h0;
  logic [7:0] node_data = 8'h00;
  logic [7:0] rd_data, got_data, s;
  logic [15:0] low_run;
  logic rxd_pin_owned, txd_out, txd_oe, irq_req, node_line, sending, txd_line, rxd_line;
  logic [7:0] tf [4] = '{8'h00, 8'h02, 8'h03, 8'h02};
  logic [7:0] td [4] = '{8'h55, 8'h03, 8'h03, 8'h01};
  logic [7:0] te [4] = '{8'h55, 8'h03, 8'h83, 8'h81};
  int mismatches = 0;
  int n_checks = 0;
  // pull-up on the shared line when nobody drives it
  assign txd_line = txd_oe ? txd_out : 1'h1;
  assign rxd_line = hold_low ? 1'h0 : node_line;
  always #2.5 clk = ~clk;
  spc_top dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data(rd_data), .wait_mode(wait_mode), .rxd_in(rxd_line),
    .rxd_pin_owned(rxd_pin_owned), .txd_in(txd_line), .txd_out(txd_out), .txd_oe(txd_oe),
    .irq_req(irq_req));
  spc_remote_node node (.clk(clk), .bit_clks(16'h0010), .send_go(node_go),
    .send_data(node_data), .line_out(node_line), .sending(sending), .line_in(txd_line),
    .got_data(got_data), .low_run(low_run));
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'h1;
    @(posedge clk);
    wr_stb <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'h1;
    @(posedge clk);
    rd_stb <= 1'h0;
    #1;
    d = rd_data;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk(16'(got), 16'(exp));
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(16'(d), 16'(exp));
  endtask
  // bounded poll of one status flag
  task automatic poll(input int b);
    logic [7:0] d;
    d = 8'h00;
    for (int n = 0; n < 300 && d[b] !== 1'h1; n++)
      rd(STA, d);
    chk1(d[b], 1'h1);
  endtask
  task automatic send(input logic [7:0] d);
    node_data <= d;
    node_go <= 1'h1;
    @(posedge clk);
    node_go <= 1'h0;
    #1;
    for (int n = 0; n < 1000 && sending !== 1'h0; n++)
      @(posedge clk);
    chk1(sending, 1'h0);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // watchdog, several times the expected run
  initial
  begin
    #200000;
    mismatches++;
    close_out;
  end
  initial
  begin
    repeat (3) @(posedge clk);
    reset_n <= 1'h1;
    rd_chk(FMT, spc_pkg::FORMAT_RESET);
    rd_chk(ENA, spc_pkg::ENABLE_RESET);
    rd_chk(STA, 8'hc0);
    rd_chk(3'h5, 8'h00);
    wr(ENA, 8'h80);
    chk1(irq_req, 1'h1);
    wr(ENA, 8'h00);
    chk1(irq_req, 1'h0);
    wr(spc_pkg::ADDR_BAUD_HI, 8'h00);
    wr(spc_pkg::ADDR_BAUD_LO, 8'h01);
    wr(ENA, 8'h08);
    chk1(txd_oe, 1'h1);
    // formats and parity, clocks kept running in wait
    wait_mode <= 1'h1;
    for (int i = 0; i < 4; i++)
    begin
      wr(FMT, tf[i]);
      wr(DAT, td[i]);
      poll(6);
      chk(16'(got_data), 16'(te[i]));
    end
    wait_mode <= 1'h0;
    // transmitter switched off in mid frame
    wr(FMT, 8'h00);
    wr(DAT, 8'h0f);
    wr(ENA, 8'h00);
    chk1(txd_oe, 1'h1);
    poll(6);
    chk1(txd_oe, 1'h0);
    chk(16'(got_data), 16'h000f);
    // short then long break
    wr(ENA, 8'h08);
    for (int i = 0; i < 2; i++)
    begin
      wr(EXT, 8'(i));
      wr(ENA, 8'h09);
      wr(ENA, 8'h08);
      poll(6);
      chk(low_run, (i == 1) ? 16'h00d0 : 16'h00a0);
    end
    wr(EXT, 8'h00);
    // reception with interrupt
    wr(ENA, 8'h24);
    chk1(rxd_pin_owned, 1'h1);
    send(8'h9a);
    poll(5);
    chk1(irq_req, 1'h1);
    rd_chk(DAT, 8'h9a);
    chk1(irq_req, 1'h0);
    // standby until address mark
    wr(FMT, 8'h08);
    wr(ENA, 8'h06);
    send(8'h01);
    rd(STA, s);
    chk1(s[5], 1'h0);
    send(8'h81);
    poll(5);
    rd_chk(DAT, 8'h81);
    rd_chk(ENA, 8'h04);
    // nine-bit internal loop ignores a stuck low input pin
    wr(FMT, 8'h90);
    wr(ENA, 8'h0c);
    hold_low <= 1'h1;
    chk1(rxd_pin_owned, 1'h0);
    wr(EXT, 8'h40);
    wr(DAT, 8'h3c);
    poll(5);
    rd_chk(DAT, 8'h3c);
    rd_chk(EXT, 8'hc0);
    hold_low <= 1'h0;
    poll(6);
    // single wire direction
    wr(FMT, 8'ha0);
    chk1(txd_oe, 1'h0);
    wr(EXT, 8'h20);
    chk1(txd_oe, 1'h1);
    // frozen in wait mode
    wr(FMT, 8'h40);
    wr(DAT, 8'h00);
    repeat (24) @(posedge clk);
    wait_mode <= 1'h1;
    repeat (400) @(posedge clk);
    rd(STA, s);
    chk1(s[6], 1'h0);
    wait_mode <= 1'h0;
    poll(6);
    close_out;
  end
endmodule
